/* hdl/dscs_clock_select.sv */
// How it works
// - double speed cycle takes six oscillator periods
// - divide-by-two stage, bypassable by software
// - programmed fuse starts in double speed
// - global selector switches twelve versus six periods
// - unprogrammed fuse resets into standard speed
// - global selector alone doubles the cpu and all peripherals
// - peripheral doubles only when its bit cleared
// - register 8Fh holds selectors bits 7..0
// - standard mode uses halved oscillator for everything
// - global change applied on halved clock rising edge
// - doubled peripheral time base runs twice faster
module dscs_clock_select (
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic OSC_TICK_I,
  input wire logic FUSE_I,
  input wire logic SFR_WR_I,
  input wire logic SFR_RD_I,
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic [7:0] SFR_WDATA_I,
  output logic [7:0] SFR_RDATA_O,
  output logic SFR_HIT_O,
  output logic CPU_DOUBLE_O,
  output logic CPU_TICK_O,
  output logic CPU_CYCLE_O,
  output logic [6:0] PERIPH_TICK_O,
  output logic [6:0] PERIPH_DOUBLE_O
);
  // ==========================================
  // input synchronisers
  logic [1:0] osc_sync; // oscillator period pulse, two flops
  logic [1:0] fuse_sync; // fuse level, two flops
  logic osc_prev; // previous synced oscillator level

  // two flop synchroniser for the oscillator input
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      osc_sync <= 2'h0;
      osc_prev <= 1'b0;
    end else begin
      osc_sync <= {osc_sync[0], OSC_TICK_I};
      osc_prev <= osc_sync[1];
    end
  end

  // fuse synchroniser runs through reset, so the level is settled at release
  always_ff @(posedge CLOCK_I) begin
    fuse_sync <= {fuse_sync[0], FUSE_I};
  end

  // one oscillator period per rising edge of the synced input
  logic osc_tick;
  assign osc_tick = osc_sync[1] & ~osc_prev;

  // ==========================================
  // state
  typedef struct packed {
    logic [7:0] ctrl; // clock speed control register
    logic strap_done; // fuse sampled after reset
    logic half; // halved oscillator phase
    dscs_pkg::dscs_mode_t mode; // applied cpu mode
    logic cpu_tick; // cpu period enable
    logic [6:0] periph_tick; // peripheral period enables
    logic [6:0] periph_double; // peripheral doubled flags
    logic [7:0] rdata; // read data
    logic hit; // address decoded
  } dscs_state_t;
  dscs_state_t state;
  dscs_state_t next_state;

  // peripheral field positions in register order
  function automatic logic periph_sel(input logic [7:0] ctrl, input int idx);
    periph_sel = ctrl[dscs_pkg::TIMER_ZERO_BIT + idx];
  endfunction

  logic half_rise; // rising edge of halved clock
  logic std_tick; // standard rate enable
  logic dbl_tick; // double rate enable
  logic [7:0] ctrl_eff; // register value after a write

  // ==========================================
  // next state
  always_comb begin
    next_state = state;
    half_rise = 1'b0;
    std_tick = 1'b0;
    dbl_tick = osc_tick;
    ctrl_eff = state.ctrl;
    // divide by two of oscillator periods
    if (osc_tick) begin
      next_state.half = ~state.half;
      half_rise = ~state.half;
      std_tick = ~state.half;
    end
    // fuse captured once after reset release
    if (!state.strap_done) begin
      next_state.strap_done = 1'b1;
      if (fuse_sync[1]) begin
        next_state.ctrl[dscs_pkg::GLOBAL_BIT] = 1'b1;
        next_state.mode = dscs_pkg::DSCS_DBL;
      end
      ctrl_eff = next_state.ctrl;
    end
    // register write at its address
    if (SFR_WR_I && SFR_ADDR_I == dscs_pkg::CLK_CTRL_ADDR) begin
      next_state.ctrl = SFR_WDATA_I;
      ctrl_eff = SFR_WDATA_I;
    end
    // global selector applied on halved rising edge
    if (half_rise && state.strap_done) begin
      next_state.mode = ctrl_eff[dscs_pkg::GLOBAL_BIT] ? dscs_pkg::DSCS_DBL : dscs_pkg::DSCS_STD;
    end
    // cpu tick: bypass divider in double mode
    next_state.cpu_tick = (state.mode == dscs_pkg::DSCS_DBL) ? dbl_tick : std_tick;
    // peripheral ticks
    for (int i = 0; i < dscs_pkg::NUM_PERIPH; i++) begin
      next_state.periph_double[i] = (state.mode == dscs_pkg::DSCS_DBL) && !periph_sel(state.ctrl, i);
      next_state.periph_tick[i] = next_state.periph_double[i] ? dbl_tick : std_tick;
    end
    // read path
    next_state.hit = (SFR_RD_I || SFR_WR_I) && SFR_ADDR_I == dscs_pkg::CLK_CTRL_ADDR;
    next_state.rdata = (SFR_RD_I && SFR_ADDR_I == dscs_pkg::CLK_CTRL_ADDR) ? state.ctrl : 8'h00;
  end

  // register the state
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      state <= '0;
      state.ctrl <= dscs_pkg::CLK_CTRL_RESET;
      state.mode <= dscs_pkg::DSCS_STD;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================
  // machine cycle counter over oscillator periods: 12 or 6
  logic [3:0] cycle_last;
  logic cpu_cycle;
  assign cycle_last = (state.mode == dscs_pkg::DSCS_DBL) ? dscs_pkg::DBL_LAST : dscs_pkg::PERIOD_LAST;
  dscs_cycle_gen u_cycle (
    .CLOCK_I(CLOCK_I),
    .RST_I(RST_I),
    .tick_i(osc_tick),
    .last_i(cycle_last),
    .cycle_o(cpu_cycle)
  );

  // outputs straight from flops
  assign SFR_RDATA_O = state.rdata;
  assign SFR_HIT_O = state.hit;
  assign CPU_DOUBLE_O = state.mode;
  assign CPU_TICK_O = state.cpu_tick;
  assign CPU_CYCLE_O = cpu_cycle;
  assign PERIPH_TICK_O = state.periph_tick;
  assign PERIPH_DOUBLE_O = state.periph_double;

  // ==========================================
  // checks
  chk_std_reset_mode: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    $rose(state.strap_done) && !fuse_sync[1] |=> !state.mode) else $error("fuse clear left double");
  chk_fuse_fast_start: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    $rose(state.strap_done) && fuse_sync[1] |=> state.mode) else $error("fuse did not start double");
  chk_mode_on_edge: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    $changed(state.mode) && $past(state.strap_done) |-> $past(half_rise)) else $error("mode off edge");
  chk_std_tick_rate: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    !state.mode && !$past(state.mode) && state.cpu_tick |-> $past(std_tick)) else $error("cpu not halved");
  chk_dbl_tick_rate: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    state.mode && $past(state.mode) && $past(osc_tick) |-> state.cpu_tick) else $error("divider not bypassed");
  chk_global_gate: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    !$past(state.mode) |-> state.periph_double == 7'h00) else $error("periph doubled in std");
  chk_periph_select: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    $past(state.mode) |-> state.periph_double == ~$past(state.ctrl[7:1])) else $error("periph select wrong");
  chk_reg_readback: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    SFR_RD_I && !SFR_WR_I && SFR_ADDR_I == dscs_pkg::CLK_CTRL_ADDR |=> SFR_RDATA_O == $past(state.ctrl))
    else $error("readback wrong");
  chk_cycle_len: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    cpu_cycle && state.mode |-> u_cycle.state.count == 4'h0) else $error("cycle wrap");
endmodule

/* hdl/dscs_pkg.sv */
package dscs_pkg;
  // ==========================================
  // register map
  localparam logic [7:0] CLK_CTRL_ADDR = 8'h8F; // clock speed control address
  localparam logic [7:0] CLK_CTRL_RESET = 8'h00; // reset value
  // ==========================================
  // field positions in clock speed control
  localparam int GLOBAL_BIT = 0; // global double speed selector
  localparam int TIMER_ZERO_BIT = 1; // timer 0 selector
  localparam int TIMER_ONE_BIT = 2; // timer 1 selector
  localparam int TIMER_TWO_BIT = 3; // timer 2 selector
  localparam int UART_BIT = 4; // uart selector
  localparam int COUNTER_ARRAY_BIT = 5; // counter array selector
  localparam int WATCHDOG_BIT = 6; // watchdog selector
  localparam int CAN_BIT = 7; // can selector
  localparam int NUM_PERIPH = 7; // peripheral clock count
  // ==========================================
  // cycle counts in oscillator periods
  localparam logic [3:0] STD_PERIODS = 4'hC; // standard speed periods per cycle
  localparam logic [3:0] DBL_PERIODS = 4'h6; // double speed periods per cycle
  localparam logic [3:0] PERIOD_LAST = 4'hB; // last count in a standard cycle
  localparam logic [3:0] DBL_LAST = 4'h5; // last count in a double cycle
  // ==========================================
  // mode enumeration
  typedef enum logic [0:0] {
    DSCS_STD = 1'b0, // standard speed mode
    DSCS_DBL = 1'b1 // double speed mode
  } dscs_mode_t;
endpackage

/* hdl/dscs_cycle_gen.sv */
// ==========================================
// machine cycle counter: one pulse every n enables
module dscs_cycle_gen (
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic tick_i,
  input wire logic [3:0] last_i,
  output logic cycle_o
);
  // ==========================================
  // state
  typedef struct packed {
    logic [3:0] count; // periods in current cycle
    logic cycle; // end of cycle pulse
  } dscs_cg_state_t;
  dscs_cg_state_t state;
  dscs_cg_state_t next_state;

  // count enables, wrap at last
  always_comb begin
    next_state = state;
    next_state.cycle = 1'b0;
    if (tick_i) begin
      if (state.count >= last_i) begin
        next_state.count = 4'h0;
        next_state.cycle = 1'b1;
      end else begin
        next_state.count = state.count + 4'h1;
      end
    end
  end

  // register the state
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign cycle_o = state.cycle;
endmodule

/* tb/dscs_osc_model.sv */
// ==========================================
// free running oscillator model
module dscs_osc_model (
  input wire logic clk_i,
  output logic osc_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // half period in system clocks, keeps three clocks high and low
  localparam int HALF = 3;
  int cnt = 0;
  initial osc_o = 1'b0;
  // toggle off the sampling edge, never stops like a crystal
  always @(negedge clk_i) begin
    cnt = (cnt + 1) % HALF;
    if (cnt == 0) osc_o = ~osc_o;
  end
endmodule

/* tb/dscs_clock_select_tb_top.sv */
// ==========================================
// bench top: register access and clock rate checks
module dscs_clock_select_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic fuse = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  int pidx = 7;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [6:0] ptick;
  logic [6:0] pdbl;
  logic osc, hit, cdbl, ctick, ccyc;
  int fail_count = 0;
  int checked = 0;
  // probe picks a peripheral tick, machine cycle (7) or cpu tick (8)
  wire probe = (pidx == 7) ? ccyc : (pidx == 8) ? ctick : ptick[pidx];
  always #5 clock = ~clock;
  dscs_osc_model dscs_osc_model_inst (.clk_i(clock), .osc_o(osc));
  dscs_clock_select dscs_clock_select_inst (.CLOCK_I(clock), .RST_I(rst), .OSC_TICK_I(osc), .FUSE_I(fuse),
    .SFR_WR_I(wr), .SFR_RD_I(rd), .SFR_ADDR_I(addr), .SFR_WDATA_I(wdata), .SFR_RDATA_O(rdata),
    .SFR_HIT_O(hit), .CPU_DOUBLE_O(cdbl), .CPU_TICK_O(ctick), .CPU_CYCLE_O(ccyc),
    .PERIPH_TICK_O(ptick), .PERIPH_DOUBLE_O(pdbl));
  // ==========================================
  // compare and closing tasks
  task automatic cmp_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cmp_count(input string name, input int exp, input int got);
    checked++;
    if (got != exp) begin
      fail_count++;
      $display("wrong value %s expected %0d seen %0d", name, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ==========================================
  // drivers, all on the falling edge
  task automatic do_reset(input logic f);
    @(negedge clock);
    rst = 1'b1;
    fuse = f;
    repeat (10) @(negedge clock);
    rst = 1'b0;
    repeat (3) @(negedge clock);
  endtask
  // write, then let the mode settle over several halved clocks
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clock);
    wr = 1'b0;
    repeat (30) @(negedge clock);
  endtask
  task automatic reg_chk(input logic [7:0] a, input logic [7:0] d, input logic h);
    @(negedge clock);
    rd = 1'b1;
    addr = a;
    @(negedge clock);
    rd = 1'b0;
    cmp_byte("read data", d, rdata);
    cmp_byte("hit", {7'h00, h}, {7'h00, hit});
  endtask
  // clocks between two pulses of the probe, bounded
  task automatic spacing(input int s, output int n);
    int k;
    pidx = s;
    k = 0;
    @(negedge clock);
    while (probe !== 1'b1 && k < 200) begin
      @(negedge clock);
      k++;
    end
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (probe !== 1'b1 && n < 200);
  endtask
  // oscillator period is six clocks: 12 periods 72, 6 periods 36
  task automatic check_mode(input logic c, input logic [6:0] p, input int cyc, input int pi, input int pt);
    int n;
    cmp_byte("cpu mode", {7'h00, c}, {7'h00, cdbl});
    cmp_byte("periph mode", {1'b0, p}, {1'b0, pdbl});
    spacing(7, n);
    cmp_count("cycle length", cyc, n);
    spacing(8, n);
    cmp_count("cpu tick", cyc / 6, n);
    spacing(pi, n);
    cmp_count("periph tick", pt, n);
  endtask
  // ==========================================
  // scenarios
  task automatic t_standard;
    reg_chk(8'h8F, 8'h00, 1'b1);
    reg_chk(8'h8E, 8'h00, 1'b0);
    check_mode(1'b0, 7'h00, 72, 6, 12);
  endtask
  task automatic t_cpu_only;
    sfr_write(8'h8F, 8'hFF);
    reg_chk(8'h8F, 8'hFF, 1'b1);
    check_mode(1'b1, 7'h00, 36, 3, 12);
  endtask
  // one peripheral selector cleared at a time
  task automatic t_each_periph;
    int n;
    for (int b = 0; b < 7; b++) begin
      sfr_write(8'h8F, 8'hFF ^ (8'h02 << b));
      check_mode(1'b1, 7'h01 << b, 36, b, 6);
      spacing((b + 1) % 7, n);
      cmp_count("other periph tick", 12, n);
    end
  endtask
  task automatic t_back_standard;
    sfr_write(8'h8F, 8'h00);
    check_mode(1'b0, 7'h00, 72, 4, 12);
  endtask
  task automatic t_fuse;
    do_reset(1'b1);
    reg_chk(8'h8F, 8'h01, 1'b1);
    check_mode(1'b1, 7'h7F, 36, 6, 6);
  endtask
  // ==========================================
  // main sequence and watchdog
  initial begin
    do_reset(1'b0);
    t_standard;
    t_cpu_only;
    t_each_periph;
    t_back_standard;
    t_fuse;
    complete_run;
  end
  initial begin
    #300us;
    fail_count++;
    complete_run;
  end
endmodule
